/* File: ast_pkg.sv */
package ast_pkg;
  // register indices; byte address is four times the index
  localparam int IDX_W = 18;
  localparam logic [17:0] STATUS_IDX = 18'h0F29E;
  localparam logic [17:0] BUFFER_IDX = 18'h0F29F;
  localparam logic [17:0] CONTROL_IDX = 18'h0F2A0;
  localparam logic [17:0] MODE_IDX = 18'h0F2A1;
  localparam logic [17:0] FORMAT_IDX = 18'h0F2A2;
  localparam logic [17:0] BAUD_IDX = 18'h0F2A3;
  // status field positions
  localparam int ST_FER = 0;
  localparam int ST_OER = 1;
  localparam int ST_PER = 2;
  localparam int ST_FUL = 3;
  // control, mode and format field positions
  localparam int EN_BIT = 0;
  localparam int IO_BIT = 0;
  localparam int RSS_BIT = 1;
  localparam int LEN_LSB = 0;
  localparam int PAR_LSB = 2;
  localparam int STOP_BIT = 4;
  localparam int NEG_BIT = 5;
  localparam int DIR_BIT = 6;
  // reset values
  localparam logic [6:0] FORMAT_RST = 7'h00;
  localparam logic [11:0] BAUD_RST = 12'hFFF;
  localparam logic [7:0] BUFFER_RST = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP, TX_END}
    ast_tx_state_t;
  typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_PAR, RX_XFER,
    RX_STOP} ast_rx_state_t;

  // length code 00..11 gives 8..5 data bits
  function automatic logic [3:0] data_len(input logic [1:0] code);
    return 4'h8 - {2'h0, code};
  endfunction : data_len

  // buffer bit carried by serial slot idx
  function automatic logic [2:0] bit_pos(input logic [2:0] idx,
    input logic [3:0] len, input logic msb);
    logic [3:0] p;
    p = msb ? (len - 4'h1 - {1'h0, idx}) : {1'h0, idx};
    return p[2:0];
  endfunction : bit_pos

  // parity bit over the valid data bits; even unless odd is set
  function automatic logic par_calc(input logic [7:0] data,
    input logic [3:0] len, input logic odd);
    logic [7:0] mask;
    mask = 8'hFF >> (4'h8 - len);
    return (^(data & mask)) ^ odd;
  endfunction : par_calc

  function automatic logic is_mapped(input logic [17:0] idx);
    return idx == STATUS_IDX || idx == BUFFER_IDX || idx == CONTROL_IDX ||
      idx == MODE_IDX || idx == FORMAT_IDX || idx == BAUD_IDX;
  endfunction : is_mapped
endpackage : ast_pkg

/* File: ast_reg_if.sv */
`timescale 1ns/1ps
// register port between the bus slave and the channel core
interface ast_reg_if;
  logic wr;
  logic [17:0] widx;
  logic [15:0] wdata;
  logic whit;
  logic rd;
  logic [17:0] ridx;
  logic [15:0] rdata;
  logic rhit;
  modport bus (output wr, widx, wdata, rd, ridx, input whit, rdata, rhit);
  modport regs (input wr, widx, wdata, rd, ridx, output whit, rdata, rhit);
endinterface : ast_reg_if

/* File: ast_axil_slave.sv */
`timescale 1ns/1ps
module ast_axil_slave #(
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  ast_reg_if.bus rb
);
  if (ADDR_W != ast_pkg::IDX_W + 2)
    $error("address width must be index width plus two");

  logic aw_full_reg, w_full_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic w_strb_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic do_wr;

  // address and data are held apart so either may come first
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready = !w_full_reg;
  assign do_wr = aw_full_reg && w_full_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  // only the low byte lane strobe commits a write
  assign rb.wr = do_wr && w_strb_reg;
  assign rb.widx = aw_addr_reg[ADDR_W-1:2];
  assign rb.wdata = w_data_reg;
  assign rb.rd = s_axi_arvalid && !rvalid_reg;
  assign rb.ridx = s_axi_araddr[ADDR_W-1:2];

  // write channels and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 1'b0;
      bresp_reg <= ast_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      else if (do_wr)
        aw_full_reg <= 1'b0;
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[15:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      else if (do_wr)
        w_full_reg <= 1'b0;
      if (do_wr)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= rb.whit ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= ast_pkg::RESP_OKAY;
    end
    else if (rb.rd)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg <= {16'h0000, rb.rdata};
      rresp_reg <= rb.rhit ? ast_pkg::RESP_OKAY : ast_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid_reg && !s_axi_bready |=> bvalid_reg && $stable(bresp_reg))
    else $error("write response dropped before bready");
endmodule : ast_axil_slave

/* File: ast_baud_gen.sv */
`timescale 1ns/1ps
module ast_baud_gen #(
  parameter int CNT_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic [CNT_W-1:0] count,
  input wire logic shift,
  output logic bit_end,
  output logic mid
);
  if (CNT_W < 2 || CNT_W > 12)
    $error("count width must be 2 to 12");

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] mid_pt;
  logic [CNT_W-1:0] half;

  // about half a bit after the start edge was seen, not at the bit's end
  assign half = count - (count >> 1);
  // shift moves the sample one source clock later, never past bit end
  assign mid_pt = (shift && half != '0) ? half - 1'b1 : half; // R22
  assign bit_end = run && cnt_reg == '0;
  assign mid = run && cnt_reg == mid_pt;

  // count+1 source clocks per bit; reloads while stopped
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= ast_pkg::BAUD_RST[CNT_W-1:0];
    else if (!run || cnt_reg == '0)
      cnt_reg <= count; // R8
    else
      cnt_reg <= cnt_reg - 1'b1;
  end

  reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bit_end |=> cnt_reg == $past(count)) // R8
    else $error("bit counter did not reload");
endmodule : ast_baud_gen

/* File: ast_serial.sv */
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Operation
// R1 - any write to the status register clears all four flags
// R2 - framing flag reflects start/stop errors per reception; zero in transmit
// R3 - overrun set when a byte arrives while the previous is unread
// R4 - parity flag refreshed per reception; zero in transmit mode
// R5 - buffer-full set by a transmit write, cleared when byte is loaded
// R6 - software checks buffer-full is zero before writing the next byte
// R7 - frame: start, 5-8 data, optional parity, 1-2 stops, order, polarity
// R8 - bit time is count+1 source clocks, 12-bit count
// R9 - software programs count as clock over bit rate minus one
// R10 - transmit starts when direction is transmit and run is set
// R11 - start bit on falling transfer edge, then data, parity, stops
// R12 - interrupt request when the start bit is output
// R13 - after stop: continue with interrupt, or clear run and interrupt
// R14 - software writes next byte before the current stop bit ends
// R15 - transmit pin held high in receive mode
// R16 - software picks input, sets receive direction, then sets run
// R17 - receiver hunts for start and times bits from its edge
// R18 - bits sampled mid-bit; byte moves to buffer on following fall
// R19 - next rise: interrupt, stop and parity checked, flags set
// R20 - reception repeats until run is cleared by software
// R21 - start bit sampled every source clock, one clock latency
// R22 - sample point shiftable by one source clock
// R23 - length codes 00..11 give 8, 7, 6, 5 data bits
// R24 - parity code 00 even, 01 odd, upper bit set none
// R25 - negative logic inverts every serial bit both ways
module ast_serial #(
  parameter int BAUD_W = 12,
  parameter int ADDR_W = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic irq_req
);
  if (BAUD_W != 12)
    $error("the bit counter is twelve bits wide");

  ast_reg_if rb ();

  logic run_reg, dir_reg, rss_reg;
  logic [6:0] fmt_reg;
  logic [BAUD_W-1:0] baud_reg;
  logic [7:0] buf_reg;
  logic fer_reg, oer_reg, per_reg, ful_reg, unread_reg;
  ast_pkg::ast_tx_state_t tx_state_reg;
  ast_pkg::ast_rx_state_t rx_state_reg;
  logic [7:0] tx_shift_reg, rx_shift_reg;
  logic [2:0] tx_idx_reg, rx_idx_reg;
  logic tx_bit_reg, out_reg, irq_reg, rx_ferr_reg, rx_par_reg;
  logic be, mp, baud_run;
  logic [3:0] len;
  logic [2:0] last_idx;
  logic par_en, par_odd, two_stop, neg, msb, rx_in;
  logic wr_stat, wr_buf, wr_ctrl, wr_mode, wr_fmt, wr_baud, rd_buf, buf_wr;
  logic tx_load, tx_stop_run, rx_xfer, rx_fin, rx_stop2_bad;
  logic fer_new, per_new;

  ast_axil_slave #(.ADDR_W(ADDR_W)) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rb(rb)
  );

  // the counter runs only while a frame is active or transmit is enabled
  assign baud_run = run_reg && (!dir_reg || rx_state_reg != ast_pkg::RX_HUNT);

  ast_baud_gen #(.CNT_W(BAUD_W)) u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(baud_run),
    .count(baud_reg),
    .shift(rss_reg),
    .bit_end(be),
    .mid(mp)
  );

  // frame format decode
  assign len = ast_pkg::data_len(fmt_reg[ast_pkg::LEN_LSB +: 2]); // R23
  assign last_idx = 3'(len - 4'h1);
  assign par_en = !fmt_reg[ast_pkg::PAR_LSB + 1]; // R24
  assign par_odd = fmt_reg[ast_pkg::PAR_LSB];
  assign two_stop = fmt_reg[ast_pkg::STOP_BIT];
  assign neg = fmt_reg[ast_pkg::NEG_BIT];
  assign msb = fmt_reg[ast_pkg::DIR_BIT];
  assign rx_in = serial_in_pin ^ neg; // R25

  // register decode
  assign rb.whit = ast_pkg::is_mapped(rb.widx);
  assign rb.rhit = ast_pkg::is_mapped(rb.ridx);
  assign wr_stat = rb.wr && rb.widx == ast_pkg::STATUS_IDX;
  assign wr_buf = rb.wr && rb.widx == ast_pkg::BUFFER_IDX;
  assign wr_ctrl = rb.wr && rb.widx == ast_pkg::CONTROL_IDX;
  assign wr_mode = rb.wr && rb.widx == ast_pkg::MODE_IDX;
  assign wr_fmt = rb.wr && rb.widx == ast_pkg::FORMAT_IDX;
  assign wr_baud = rb.wr && rb.widx == ast_pkg::BAUD_IDX;
  assign rd_buf = rb.rd && rb.ridx == ast_pkg::BUFFER_IDX;
  assign buf_wr = wr_buf && !dir_reg;

  // read mux; unmapped indices read zero and answer with an error
  always_comb
  begin
    case (rb.ridx)
      ast_pkg::STATUS_IDX: rb.rdata = {12'h000, ful_reg, per_reg, oer_reg,
        fer_reg};
      ast_pkg::BUFFER_IDX: rb.rdata = {8'h00, buf_reg};
      ast_pkg::CONTROL_IDX: rb.rdata = {15'h0000, run_reg};
      ast_pkg::MODE_IDX: rb.rdata = {14'h0000, rss_reg, dir_reg};
      ast_pkg::FORMAT_IDX: rb.rdata = {9'h000, fmt_reg};
      ast_pkg::BAUD_IDX: rb.rdata = 16'(baud_reg);
      default: rb.rdata = 16'h0000;
    endcase
  end

  // frame events
  assign tx_load = be && run_reg && !dir_reg &&
    (tx_state_reg == ast_pkg::TX_IDLE ||
    (tx_state_reg == ast_pkg::TX_END && ful_reg));
  assign tx_stop_run = be && tx_state_reg == ast_pkg::TX_END && !ful_reg;
  assign rx_xfer = be && rx_state_reg == ast_pkg::RX_XFER;
  assign rx_fin = mp && rx_state_reg == ast_pkg::RX_STOP && rx_idx_reg == 3'h0;
  assign rx_stop2_bad = mp && rx_state_reg == ast_pkg::RX_STOP &&
    rx_idx_reg == 3'h1 && !rx_in;
  assign fer_new = rx_ferr_reg || !rx_in;
  assign per_new = par_en &&
    (ast_pkg::par_calc(rx_shift_reg, len, par_odd) != rx_par_reg);

  // control registers; a software write of run wins over the auto stop
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_reg <= 1'b0;
      dir_reg <= 1'b0;
      rss_reg <= 1'b0;
      fmt_reg <= ast_pkg::FORMAT_RST;
      baud_reg <= ast_pkg::BAUD_RST;
    end
    else
    begin
      if (wr_ctrl)
        run_reg <= rb.wdata[ast_pkg::EN_BIT]; // R10
      else if (tx_stop_run)
        run_reg <= 1'b0; // R13
      if (wr_mode)
      begin
        dir_reg <= rb.wdata[ast_pkg::IO_BIT];
        rss_reg <= rb.wdata[ast_pkg::RSS_BIT];
      end
      if (wr_fmt)
        fmt_reg <= rb.wdata[6:0];
      if (wr_baud)
        baud_reg <= rb.wdata[BAUD_W-1:0];
    end
  end

  // shared buffer: software fills it in transmit, the receiver in receive
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      buf_reg <= ast_pkg::BUFFER_RST;
      unread_reg <= 1'b0;
    end
    else
    begin
      if (buf_wr)
        buf_reg <= rb.wdata[7:0];
      else if (rx_xfer)
        buf_reg <= rx_shift_reg; // R18
      // unread survives a stop and restart so overrun still shows
      if (rx_xfer)
        unread_reg <= 1'b1;
      else if (rd_buf)
        unread_reg <= 1'b0;
    end
  end

  // status flags; a hardware update wins over a clearing write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fer_reg <= 1'b0;
      oer_reg <= 1'b0;
      per_reg <= 1'b0;
      ful_reg <= 1'b0;
    end
    else
    begin
      if (!dir_reg)
        fer_reg <= 1'b0; // R2
      else if (rx_fin)
        fer_reg <= fer_new; // R19
      else if (rx_stop2_bad)
        fer_reg <= 1'b1;
      else if (wr_stat)
        fer_reg <= 1'b0; // R1
      if (!dir_reg)
        oer_reg <= 1'b0;
      else if (rx_xfer && unread_reg)
        oer_reg <= 1'b1; // R3
      else if (wr_stat)
        oer_reg <= 1'b0; // R1
      if (!dir_reg)
        per_reg <= 1'b0;
      else if (rx_fin)
        per_reg <= per_new; // R4
      else if (wr_stat)
        per_reg <= 1'b0; // R1
      if (dir_reg)
        ful_reg <= 1'b0;
      else if (buf_wr)
        ful_reg <= 1'b1; // R5
      else if (tx_load || wr_stat)
        ful_reg <= 1'b0; // R5
    end
  end

  // transmitter; every bit changes on the falling transfer edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_reg <= ast_pkg::TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_idx_reg <= 3'h0;
      tx_bit_reg <= 1'b1;
    end
    else if (!run_reg || dir_reg)
    begin
      tx_state_reg <= ast_pkg::TX_IDLE;
      tx_bit_reg <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_bit_reg <= 1'b0; // R11
      tx_shift_reg <= buf_reg;
      tx_idx_reg <= 3'h0;
      tx_state_reg <= ast_pkg::TX_DATA;
    end
    else if (be)
    begin
      case (tx_state_reg)
        ast_pkg::TX_DATA:
        begin
          tx_bit_reg <= tx_shift_reg[ast_pkg::bit_pos(tx_idx_reg, len,
            msb)]; // R7
          if (tx_idx_reg == last_idx)
          begin
            tx_idx_reg <= 3'h0;
            tx_state_reg <= par_en ? ast_pkg::TX_PAR : ast_pkg::TX_STOP;
          end
          else
            tx_idx_reg <= tx_idx_reg + 3'h1;
        end
        ast_pkg::TX_PAR:
        begin
          tx_bit_reg <= ast_pkg::par_calc(tx_shift_reg, len, par_odd);
          tx_state_reg <= ast_pkg::TX_STOP;
        end
        ast_pkg::TX_STOP:
        begin
          tx_bit_reg <= 1'b1;
          if (two_stop && tx_idx_reg == 3'h0)
            tx_idx_reg <= 3'h1;
          else
            tx_state_reg <= ast_pkg::TX_END;
        end
        ast_pkg::TX_IDLE, ast_pkg::TX_END: tx_bit_reg <= 1'b1;
        default: tx_state_reg <= ast_pkg::TX_IDLE;
      endcase
    end
  end

  // receiver; start edge seen on any source clock restarts bit timing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_reg <= ast_pkg::RX_HUNT;
      rx_shift_reg <= 8'h00;
      rx_idx_reg <= 3'h0;
      rx_ferr_reg <= 1'b0;
      rx_par_reg <= 1'b0;
    end
    else if (!run_reg || !dir_reg)
      rx_state_reg <= ast_pkg::RX_HUNT; // R20
    else
    begin
      case (rx_state_reg)
        ast_pkg::RX_HUNT:
          if (!rx_in)
          begin
            rx_state_reg <= ast_pkg::RX_START; // R21
            rx_ferr_reg <= 1'b0;
            rx_shift_reg <= 8'h00;
            rx_idx_reg <= 3'h0;
          end
        ast_pkg::RX_START:
          if (mp)
          begin
            rx_ferr_reg <= rx_in; // R17
            rx_state_reg <= ast_pkg::RX_DATA;
          end
        ast_pkg::RX_DATA:
          if (mp)
          begin
            rx_shift_reg[ast_pkg::bit_pos(rx_idx_reg, len, msb)] <=
              rx_in; // R18
            if (rx_idx_reg == last_idx)
            begin
              rx_idx_reg <= 3'h0;
              rx_state_reg <= par_en ? ast_pkg::RX_PAR : ast_pkg::RX_XFER;
            end
            else
              rx_idx_reg <= rx_idx_reg + 3'h1;
          end
        ast_pkg::RX_PAR:
          if (mp)
          begin
            rx_par_reg <= rx_in;
            rx_state_reg <= ast_pkg::RX_XFER;
          end
        ast_pkg::RX_XFER:
          if (be)
            rx_state_reg <= ast_pkg::RX_STOP;
        ast_pkg::RX_STOP:
          if (mp)
          begin
            // back to hunting at mid stop so the next start is not missed
            if (two_stop && rx_idx_reg == 3'h0)
              rx_idx_reg <= 3'h1;
            else
              rx_state_reg <= ast_pkg::RX_HUNT;
          end
        default: rx_state_reg <= ast_pkg::RX_HUNT;
      endcase
    end
  end

  // pin and interrupt drivers, registered to keep the pin glitch free
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      out_reg <= 1'b1;
      irq_reg <= 1'b0;
    end
    else
    begin
      out_reg <= dir_reg ? 1'b1 : (tx_bit_reg ^ neg); // R15
      irq_reg <= tx_load || tx_stop_run || rx_fin; // R12
    end
  end

  assign serial_out_pin = out_reg;
  assign irq_req = irq_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence start_bit_s;
    !tx_bit_reg && irq_reg ##1 serial_out_pin == neg;
  endsequence

  status_clear_a: assert property (wr_stat && !rx_fin && !rx_xfer && // R1
    !buf_wr && !rx_stop2_bad |=> {ful_reg, per_reg, oer_reg, fer_reg} == 4'h0)
    else $error("status write did not clear the flags");
  fer_tx_zero_a: assert property (!dir_reg |=> !fer_reg && !per_reg) // R2
    else $error("receive error flag set in transmit mode");
  overrun_set_a: assert property (rx_xfer && unread_reg |=> oer_reg) // R3
    else $error("overrun not flagged");
  parity_upd_a: assert property (rx_fin |=> per_reg == $past(per_new)) // R4
    else $error("parity flag not refreshed");
  full_flag_a: assert property (buf_wr |=> ful_reg ##1 !dir_reg) // R5
    else $error("buffer full not set by write");
  start_out_a: assert property (tx_load && !neg |=> start_bit_s) // R11
    else $error("start bit or its interrupt missing");
  tx_stop_a: assert property (tx_stop_run && !wr_ctrl |=> // R13
    !run_reg && irq_req)
    else $error("transmit end did not stop and interrupt");
  rx_idle_high_a: assert property (dir_reg ##1 dir_reg |=> // R15
    serial_out_pin)
    else $error("transmit pin not high in receive mode");
  rx_irq_a: assert property (rx_fin |=> irq_req) // R19
    else $error("no interrupt at end of reception");
endmodule : ast_serial

/* File: ast_line_dev.sv */
`timescale 1ns/1ps
// far-end serial sender; the line idles high, as with a pull-up
module ast_line_dev (
  input wire logic aclk,
  output logic line
);
  initial line = 1'b1;
  // 8 data bits lsb first, even parity, one stop; faults on request
  task automatic send(input logic [7:0] d, input logic bad_par,
    input logic bad_stop, input int cyc);
    logic [10:0] f;
    f = {~bad_stop, ^d ^ bad_par, d, 1'b0};
    @(posedge aclk);
    for (int i = 0; i < 11; i++)
    begin
      line <= f[i];
      repeat (cyc) @(posedge aclk);
    end
    line <= 1'b1;
  endtask : send
endmodule : ast_line_dev

/* File: testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module testbench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sin, sout, irq;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [7:0] b;
  logic [7:0] c;
  logic [15:0] v1, v2;
  logic [1:0] exp_r;
  logic [31:0] exp_w, msk_w;
  logic [31:0] eq[$], mq[$];
  logic [1:0] rq[$];
  int num_errors, n_compared, irqs, cyc;
  ast_serial #(.BAUD_W(12), .ADDR_W(20)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_in_pin(sin), .serial_out_pin(sout), .irq_req(irq));
  ast_line_dev dev (.aclk(aclk), .line(sin));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // write: address and data offered together, each released when taken
  task automatic wr(input logic [17:0] idx, input logic [31:0] d);
    bit ad, wd;
    ad = 0;
    wd = 0;
    awaddr <= {idx, 2'h0};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (awvalid && awready) begin ad = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  // read: the expectation is noted before the request goes out
  task automatic rd(input logic [17:0] idx, input logic [31:0] e,
    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
    eq.push_back(e & m);
    mq.push_back(m);
    rq.push_back(r);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // n pin bits, one per bit time of four cycles, from mid first data bit
  task automatic grab(input int n, output logic [15:0] v);
    v = 16'h0000;
    while (sout !== 1'b0) @(posedge aclk);
    repeat (6) @(posedge aclk);
    for (int k = 0; k < n; k++)
    begin
      if (k > 0)
        repeat (4) @(posedge aclk);
      v[k] = sout;
    end
  endtask : grab
  // 7 data bits msb first, odd parity, two stops
  function automatic logic [15:0] exp7(input logic [7:0] d);
    return {6'h00, 2'h3, ~^d[6:0], d[0], d[1], d[2], d[3], d[4], d[5], d[6]};
  endfunction : exp7
  // the watcher pairs each returned word with the oldest note
  always @(posedge aclk)
  begin
    if (rvalid && rready && eq.size() > 0)
    begin
      exp_w = eq.pop_front();
      msk_w = mq.pop_front();
      exp_r = rq.pop_front();
      `CHK("rdata", exp_w, rdata & msk_w)
      `CHK("rresp", exp_r, rresp)
    end
  end
  // pulse counter and hang guard; the run needs about 500 cycles
  always @(posedge aclk)
  begin
    irqs = irq ? irqs + 1 : irqs;
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test();
    end
  end
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 72'h0;
    wstrb = 4'hF;
    aresetn = 1'b0;
    void'($urandom(32'h4C951743));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ast_pkg::STATUS_IDX, 32'h0);
    rd(ast_pkg::BAUD_IDX, 32'hFFF);
    rd(18'h00001, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(ast_pkg::BAUD_IDX, 32'h3);
    wr(ast_pkg::FORMAT_IDX, 32'h0);
    wr(ast_pkg::MODE_IDX, 32'h0);
    b = 8'($urandom);
    wr(ast_pkg::BUFFER_IDX, {24'h0, b});
    rd(ast_pkg::STATUS_IDX, 32'h8);
    irqs = 0;
    wr(ast_pkg::CONTROL_IDX, 32'h1);
    grab(10, v1);
    `CHK("tx frame", {6'h00, 1'b1, ^b, b}, v1)
    repeat (12) @(posedge aclk);
    rd(ast_pkg::STATUS_IDX, 32'h0);
    rd(ast_pkg::CONTROL_IDX, 32'h0);
    `CHK("irq count", 2, irqs)
    // chained frames: next byte written after the start interrupt
    c = 8'($urandom);
    wr(ast_pkg::FORMAT_IDX, 32'h55);
    irqs = 0;
    wr(ast_pkg::BUFFER_IDX, {24'h0, b});
    wr(ast_pkg::CONTROL_IDX, 32'h1);
    fork
      grab(10, v1);
      begin
        while (irq !== 1'b1) @(posedge aclk);
        rd(ast_pkg::STATUS_IDX, 32'h0);
        wr(ast_pkg::BUFFER_IDX, {24'h0, c});
      end
    join
    grab(10, v2);
    repeat (4) @(posedge aclk);
    `CHK("chain 1", exp7(b), v1)
    `CHK("chain 2", exp7(c), v2)
    `CHK("chain irqs", 3, irqs)
    rd(ast_pkg::CONTROL_IDX, 32'h0);
    wr(ast_pkg::FORMAT_IDX, 32'h0);
    wr(ast_pkg::MODE_IDX, 32'h3);
    wr(ast_pkg::CONTROL_IDX, 32'h1);
    `CHK("tx idle", 1'b1, sout)
    dev.send(b, 1'b1, 1'b0, 4);
    repeat (8) @(posedge aclk);
    rd(ast_pkg::BUFFER_IDX, {24'h0, b});
    rd(ast_pkg::STATUS_IDX, 32'h4);
    wr(ast_pkg::STATUS_IDX, 32'hF);
    rd(ast_pkg::STATUS_IDX, 32'h0);
    dev.send(b, 1'b0, 1'b0, 4);
    dev.send(~b, 1'b0, 1'b0, 4);
    repeat (8) @(posedge aclk);
    rd(ast_pkg::STATUS_IDX, 32'h2);
    rd(ast_pkg::BUFFER_IDX, {24'h0, ~b});
    wr(ast_pkg::STATUS_IDX, 32'h0);
    dev.send(b, 1'b0, 1'b1, 4);
    repeat (60) @(posedge aclk);
    rd(ast_pkg::STATUS_IDX, 32'h1, 32'h1);
    @(posedge aclk);
    finish_test();
  end
endmodule : testbench
